// >>> src/acc_top.sv
// Comparator control core: register slave, source routing, reference ladder, interrupts
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module acc_top (
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic [acc_pkg::AW-1:0]      avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [acc_pkg::DW-1:0]      avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [acc_pkg::DW-1:0]      avs_readdata_o,
  output logic                             avs_waitrequest_o,
  input  wire logic [acc_pkg::NCH-1:0]     comparison_result_i,
  output logic      [2*acc_pkg::NCH-1:0]   positive_source_select_o,
  output logic      [acc_pkg::NCH-1:0]     comparison_out_o,
  output logic      [acc_pkg::NCH-1:0]     comparison_out_oe_o,
  output logic                             ref_enable_o,
  output logic                             reference_range_select_o,
  output logic      [acc_pkg::TAP_W-1:0]   ref_tap_o,
  output logic                             irq_o
);
  localparam int unsigned N = acc_pkg::NCH;

  // Register state
  logic [acc_pkg::CTL_W-1:0] ctl_reg  [N];
  logic [acc_pkg::CTL_W-1:0] ctl_next [N];
  logic [acc_pkg::REF_W-1:0] ref_reg;
  logic [acc_pkg::REF_W-1:0] ref_next;
  logic [N-1:0]              inten_reg;
  logic [N-1:0]              inten_next;
  logic [N-1:0]              ris_reg;
  logic [N-1:0]              ris_next;
  logic [N-1:0]              prev_reg;
  logic [N-1:0]              prev_next;
  logic                      ack_reg;
  logic                      ack_next;
  logic [acc_pkg::DW-1:0]    rdata_reg;
  logic [acc_pkg::DW-1:0]    rdata_next;
  logic [N-1:0]              out_reg;
  logic [N-1:0]              out_next;
  logic [acc_pkg::TAP_W-1:0] tap_reg;
  logic [acc_pkg::TAP_W-1:0] tap_next;

  logic [N-1:0] cur_val;
  logic [N-1:0] event_hit;
  logic [N-1:0] mis;
  logic         req;
  logic         wr_fire;
  logic [31:0]  be_mask;

  acc_cmp_if cmp_if ();
  assign cmp_if.raw = comparison_result_i;

  acc_sync u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .cmp     (cmp_if.sync)
  );

  // Channel index of a per-channel register address, or N when none
  function automatic logic [1:0] chan_of(input logic [7:0] addr, input logic [7:0] base);
    logic [1:0] idx;
    idx = 2'(N);
    for (int i = 0; i < N; i++) begin
      if (addr == 8'(base + 8'(i) * acc_pkg::OFF_STRIDE)) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // Bit mask from byte enables
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = 8'hFF;
      end
    end
    return m;
  endfunction

  // One wait cycle on every access: answer is registered
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign wr_fire           = avs_write_i & ack_reg;
  assign be_mask           = lane_mask(avs_byteenable_i);

  // Result after optional inversion; shown in status, drives pins and events
  always_comb begin
    for (int i = 0; i < N; i++) begin
      cur_val[i] = cmp_if.value[i] ^ ctl_reg[i][acc_pkg::CTL_INV];
    end
  end

  // Event detection, independent of source select and enable
  always_comb begin
    for (int i = 0; i < N; i++) begin
      case (acc_pkg::acc_sense_t'(ctl_reg[i][acc_pkg::CTL_SENSE +: 2]))
        acc_pkg::ACC_SENSE_LEVEL: event_hit[i] = cur_val[i] == ctl_reg[i][acc_pkg::CTL_LEVEL];
        acc_pkg::ACC_SENSE_FALL:  event_hit[i] = prev_reg[i] & ~cur_val[i];
        acc_pkg::ACC_SENSE_RISE:  event_hit[i] = ~prev_reg[i] & cur_val[i];
        acc_pkg::ACC_SENSE_BOTH:  event_hit[i] = prev_reg[i] ^ cur_val[i];
        default:                  event_hit[i] = 1'b0;
      endcase
    end
  end

  assign mis = ris_reg & inten_reg;

  // Interrupt state
  always_comb begin
    prev_next = cur_val;
    ris_next  = ris_reg;
    // Clear first so a same-cycle event still sets the bit
    if (wr_fire && avs_address_i == acc_pkg::OFF_MIS) begin
      ris_next = ris_next & ~(avs_writedata_i[N-1:0] & be_mask[N-1:0]);
    end
    ris_next = ris_next | event_hit;
    inten_next = inten_reg;
    if (wr_fire && avs_address_i == acc_pkg::OFF_INTEN) begin
      inten_next = (inten_reg & ~be_mask[N-1:0]) | (avs_writedata_i[N-1:0] & be_mask[N-1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ris_reg   <= acc_pkg::IRQ_RESET;
      inten_reg <= acc_pkg::IRQ_RESET;
      prev_reg  <= acc_pkg::IRQ_RESET;
    end else begin
      ris_reg   <= ris_next;
      inten_reg <= inten_next;
      prev_reg  <= prev_next;
    end
  end

  assign irq_o = |mis;

  // Configuration registers
  always_comb begin
    logic [1:0] wch;
    wch      = chan_of(avs_address_i, acc_pkg::OFF_CTL0);
    ref_next = ref_reg;
    for (int i = 0; i < N; i++) begin
      ctl_next[i] = ctl_reg[i];
    end
    if (wr_fire) begin
      if (avs_address_i == acc_pkg::OFF_REFCTL) begin
        ref_next = ((ref_reg & ~be_mask[acc_pkg::REF_W-1:0])
                   | (avs_writedata_i[acc_pkg::REF_W-1:0] & be_mask[acc_pkg::REF_W-1:0]))
                   & acc_pkg::REF_MASK;
      end
      if (wch < 2'(N)) begin
        ctl_next[wch] = ((ctl_reg[wch] & ~be_mask[acc_pkg::CTL_W-1:0])
                        | (avs_writedata_i[acc_pkg::CTL_W-1:0] & be_mask[acc_pkg::CTL_W-1:0]))
                        & acc_pkg::CTL_MASK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_reg <= acc_pkg::REF_RESET;
      for (int i = 0; i < N; i++) begin
        ctl_reg[i] <= acc_pkg::CTL_RESET;
      end
    end else begin
      ref_reg <= ref_next;
      for (int i = 0; i < N; i++) begin
        ctl_reg[i] <= ctl_next[i];
      end
    end
  end

  // Bus answer
  always_comb begin
    logic [1:0] sch;
    logic [1:0] cch;
    sch        = chan_of(avs_address_i, acc_pkg::OFF_STAT0);
    cch        = chan_of(avs_address_i, acc_pkg::OFF_CTL0);
    ack_next   = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read_i && !ack_reg) begin
      // Unmapped addresses read zero
      rdata_next = 32'h0000_0000;
      if (avs_address_i == acc_pkg::OFF_MIS) begin
        rdata_next[N-1:0] = mis;
      end else if (avs_address_i == acc_pkg::OFF_RIS) begin
        rdata_next[N-1:0] = ris_reg;
      end else if (avs_address_i == acc_pkg::OFF_INTEN) begin
        rdata_next[N-1:0] = inten_reg;
      end else if (avs_address_i == acc_pkg::OFF_REFCTL) begin
        rdata_next[acc_pkg::REF_W-1:0] = ref_reg;
      end else if (sch < 2'(N)) begin
        rdata_next[acc_pkg::STAT_VAL] = cur_val[sch];
      end else if (cch < 2'(N)) begin
        rdata_next[acc_pkg::CTL_W-1:0] = ctl_reg[cch];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_o = rdata_reg;

  // Reference ladder tap
  always_comb begin
    logic [acc_pkg::STEP_W-1:0] step;
    step = ref_reg[acc_pkg::REF_STEP +: acc_pkg::STEP_W];
    if (!ref_reg[acc_pkg::REF_EN]) begin
      tap_next = 5'h00;
    end else if (!ref_reg[acc_pkg::REF_RANGE]) begin
      tap_next = 5'(step) + acc_pkg::TAP_OFFSET;
    end else begin
      tap_next = 5'(step);
    end
  end

  // Pin drive follows the filtered result
  always_comb begin
    out_next = cur_val;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tap_reg <= 5'h00;
      out_reg <= acc_pkg::IRQ_RESET;
    end else begin
      tap_reg <= tap_next;
      out_reg <= out_next;
    end
  end

  assign ref_tap_o                = tap_reg;
  assign ref_enable_o             = ref_reg[acc_pkg::REF_EN];
  assign reference_range_select_o = ref_reg[acc_pkg::REF_RANGE];

  // Source select passes to the analog mux; negative input has no mux at all
  // Ch0 codes 00/01 both own pin; ch1/2 code 01 picks ch0 pin; 10 picks reference
  // The analog mux decodes these literally, so routing is fixed in silicon
  always_comb begin
    for (int i = 0; i < N; i++) begin
      positive_source_select_o[2*i +: 2] = ctl_reg[i][acc_pkg::CTL_SRC +: 2];
    end
  end

  // Output driver; shared pins rely on software not also using them as inputs
  always_comb begin
    for (int i = 0; i < N; i++) begin
      comparison_out_oe_o[i] = ctl_reg[i][acc_pkg::CTL_OUTEN];
    end
  end
  assign comparison_out_o = out_reg;
endmodule // acc_top
`default_nettype wire

// >>> src/acc_pkg.sv
// Constants for the three-channel comparator control block
package acc_pkg;
  localparam int unsigned NCH        = 3;
  localparam int unsigned AW         = 8;
  localparam int unsigned DW         = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_MIS     = 8'h00;
  localparam logic [7:0] OFF_RIS     = 8'h04;
  localparam logic [7:0] OFF_INTEN   = 8'h08;
  localparam logic [7:0] OFF_REFCTL  = 8'h10;
  localparam logic [7:0] OFF_STAT0   = 8'h20;
  localparam logic [7:0] OFF_CTL0    = 8'h24;
  localparam logic [7:0] OFF_STRIDE  = 8'h20;
  // Channel control fields
  localparam int unsigned CTL_W      = 12;
  localparam int unsigned CTL_INV    = 1;
  localparam int unsigned CTL_SENSE  = 2;
  localparam int unsigned CTL_LEVEL  = 4;
  localparam int unsigned CTL_SRC    = 9;
  localparam int unsigned CTL_OUTEN  = 11;
  localparam logic [11:0] CTL_MASK   = 12'hE1E;
  localparam logic [11:0] CTL_RESET  = 12'h000;
  // Channel status field
  localparam int unsigned STAT_VAL   = 1;
  // Reference control fields
  localparam int unsigned REF_W      = 10;
  localparam int unsigned REF_STEP   = 0;
  localparam int unsigned STEP_W     = 4;
  localparam int unsigned REF_RANGE  = 8;
  localparam int unsigned REF_EN     = 9;
  localparam logic [9:0] REF_MASK    = 10'h30F;
  localparam logic [9:0] REF_RESET   = 10'h000;
  localparam int unsigned TAP_W      = 5;
  localparam logic [4:0] TAP_OFFSET  = 5'h08;
  localparam logic [2:0] IRQ_RESET   = 3'h0;

  typedef enum logic [1:0] {
    ACC_SRC_OWN   = 2'b00,
    ACC_SRC_OWN_B = 2'b01,
    ACC_SRC_REF   = 2'b10,
    ACC_SRC_RSVD  = 2'b11
  } acc_src_t;

  typedef enum logic [1:0] {
    ACC_SENSE_LEVEL = 2'b00,
    ACC_SENSE_FALL  = 2'b01,
    ACC_SENSE_RISE  = 2'b10,
    ACC_SENSE_BOTH  = 2'b11
  } acc_sense_t;
endpackage

// >>> src/acc_cmp_if.sv
// Carrier between the pin synchroniser and the control core
`timescale 1ns/100ps
`default_nettype none
interface acc_cmp_if;
  logic [acc_pkg::NCH-1:0] raw;
  logic [acc_pkg::NCH-1:0] value;
  modport sync (input raw, output value);
  modport core (output raw, input value);
endinterface
`default_nettype wire

// >>> src/acc_sync.sv
// Three-stage synchroniser with agreement filter per comparator result
`timescale 1ns/100ps
`default_nettype none
module acc_sync (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  acc_cmp_if.sync     cmp
);
  genvar g;
  generate
    for (g = 0; g < acc_pkg::NCH; g++) begin : g_ch
      logic [2:0] stage_reg;
      logic [2:0] stage_next;
      logic       val_reg;
      logic       val_next;
      always_comb begin
        stage_next = {stage_reg[1:0], cmp.raw[g]};
        // Only the second and third stages are compared, never the first
        val_next   = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : val_reg;
      end
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          stage_reg <= 3'h0;
          val_reg   <= 1'b0;
        end else begin
          stage_reg <= stage_next;
          val_reg   <= val_next;
        end
      end
      assign cmp.value[g] = val_reg;
    end
  endgenerate
endmodule // acc_sync
`default_nettype wire

// >>> src/acc_pkg_end.sv
// Empty unit: every constant of the block lives in the package file

// >>> bench/acc_asserts.sv
// Concurrent checks on the comparator control block ports
`timescale 1ns/100ps
`default_nettype none
module acc_asserts (
  input wire logic                      clk_i,
  input wire logic                      reset_i,
  input wire logic [acc_pkg::AW-1:0]    avs_address_i,
  input wire logic                      avs_read_i,
  input wire logic                      avs_write_i,
  input wire logic [acc_pkg::DW-1:0]    avs_writedata_i,
  input wire logic [3:0]                avs_byteenable_i,
  input wire logic [acc_pkg::DW-1:0]    avs_readdata_o,
  input wire logic                      avs_waitrequest_o,
  input wire logic [acc_pkg::NCH-1:0]   comparison_result_i,
  input wire logic [2*acc_pkg::NCH-1:0] positive_source_select_o,
  input wire logic [acc_pkg::NCH-1:0]   comparison_out_o,
  input wire logic [acc_pkg::NCH-1:0]   comparison_out_oe_o,
  input wire logic                      ref_enable_o,
  input wire logic                      reference_range_select_o,
  input wire logic [acc_pkg::TAP_W-1:0] ref_tap_o,
  input wire logic                      irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_idle;
    !(avs_read_i || avs_write_i);
  endsequence
  sequence s_req;
    avs_read_i || avs_write_i;
  endsequence
  sequence s_wr(logic [7:0] a);
    avs_write_i && !avs_waitrequest_o && avs_address_i == a;
  endsequence
  property p_wait_ack;
    s_idle ##1 s_req |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  property p_unmapped;
    avs_read_i && !avs_waitrequest_o && avs_address_i == 8'h0C |-> avs_readdata_o == 32'h0;
  endproperty
  property p_ref_off;
    !ref_enable_o |=> ref_tap_o == 5'h00;
  endproperty
  property p_ref_low;
    ref_enable_o && !reference_range_select_o |=> ref_tap_o inside {[5'h08:5'h17]};
  endproperty
  property p_ref_high;
    ref_enable_o && reference_range_select_o |=> ref_tap_o <= 5'h0F;
  endproperty
  property p_src0;
    s_wr(acc_pkg::OFF_CTL0) ##0 avs_byteenable_i[1] |=>
      positive_source_select_o[1:0] == $past(avs_writedata_i[10:9]) &&
      comparison_out_oe_o[0] == $past(avs_writedata_i[11]);
  endproperty
  property p_inten_off;
    s_wr(acc_pkg::OFF_INTEN) ##0 (avs_byteenable_i[0] && avs_writedata_i[2:0] == 3'h0) |=> !irq_o;
  endproperty
  property p_sync_hold;
    ($stable(comparison_result_i) && !avs_write_i) [*8] |-> $stable(comparison_out_o);
  endproperty
  property p_sync_late;
    $changed(comparison_result_i) && !avs_write_i |=> $stable(comparison_out_o);
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("waitrequest not low one cycle after request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ref_off: assert property (p_ref_off) else $error("tap not ground while reference off");
  a_ref_low: assert property (p_ref_low) else $error("low range tap out of 8 to 23");
  a_ref_high: assert property (p_ref_high) else $error("high range tap above 15");
  a_src0: assert property (p_src0) else $error("channel 0 source or enable not from write");
  a_inten_off: assert property (p_inten_off) else $error("irq high with all enables clear");
  a_sync_hold: assert property (p_sync_hold) else $error("output moved with stable input");
  a_sync_late: assert property (p_sync_late) else $error("output followed input unsynchronised");
endmodule  // acc_asserts
`default_nettype wire

// >>> bench/acc_cmp_model.sv
// Behavioural analog comparators in front of the block
`timescale 1ns/100ps
`default_nettype none
module acc_cmp_model #(
  parameter int LAT = 2
) (
  input  wire logic       clk_i,
  input  wire logic [2:0] level_i,
  output logic      [2:0] result_o
);
  logic [2:0] pipe [LAT] = '{default: 3'h0};
  // Each level is the sign of positive minus own negative pin
  // Falling edge stands in for an unrelated analog settling time
  always @(negedge clk_i) begin
    pipe[0] <= level_i;
    for (int i = 1; i < LAT; i++) pipe[i] <= pipe[i-1];
  end
  assign result_o = pipe[LAT-1];
endmodule  // acc_cmp_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o, ref_enable_o, reference_range_select_o, irq_o;
  logic [2:0]  comparison_result_i, comparison_out_o, comparison_out_oe_o;
  logic [2:0]  level = 3'h0;
  logic [5:0]  positive_source_select_o;
  logic [4:0]  ref_tap_o;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #50 clk_i = ~clk_i;
  acc_top dut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .comparison_result_i(comparison_result_i), .positive_source_select_o(positive_source_select_o),
    .comparison_out_o(comparison_out_o), .comparison_out_oe_o(comparison_out_oe_o), .ref_enable_o(ref_enable_o),
    .reference_range_select_o(reference_range_select_o), .ref_tap_o(ref_tap_o), .irq_o(irq_o));
  acc_cmp_model #(.LAT(2)) pm (.clk_i(clk_i), .level_i(level), .result_o(comparison_result_i));
  task final_report;
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Raises the request just after a rising edge, holds it until waitrequest is seen low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask
  function automatic logic [7:0] ch_addr(input int c, input logic [7:0] base);
    return base + 8'(c) * acc_pkg::OFF_STRIDE;
  endfunction
  task t_reset_vals;
    rd("masked", acc_pkg::OFF_MIS, 32'h0);
    rd("enable", acc_pkg::OFF_INTEN, 32'h0);
    rd("refctl", acc_pkg::OFF_REFCTL, 32'h0);
    rd("unmapped", 8'h0C, 32'h0);
    for (int c = 0; c < 3; c++) begin
      rd("status", ch_addr(c, acc_pkg::OFF_STAT0), 32'h0);
      rd("control", ch_addr(c, acc_pkg::OFF_CTL0), 32'h0);
    end
    @(negedge clk_i);
    chk("irq", 32'h0, irq_o);
  endtask
  task t_ref;
    logic [31:0] d;
    logic [4:0]  tap;
    for (int i = 0; i < 8; i++) begin
      d = {22'h0, i[2], i[1], 4'h0, (i[0] ? 4'hF : 4'h0)};
      tap = !i[2] ? 5'h00 : (i[1] ? {1'b0, d[3:0]} : {1'b0, d[3:0]} + 5'h08);
      wr(acc_pkg::OFF_REFCTL, d | 32'hFFFF_FCF0);
      repeat (2) @(negedge clk_i);
      chk("tap", tap, ref_tap_o);
      chk("ref flags", d[9:8], {ref_enable_o, reference_range_select_o});
      rd("refctl", acc_pkg::OFF_REFCTL, d);
    end
    wr(acc_pkg::OFF_REFCTL, 32'h100);
  endtask
  task t_src;
    for (int c = 0; c < 3; c++) begin
      for (int k = 0; k < 4; k++) begin
        wr(ch_addr(c, acc_pkg::OFF_CTL0), 32'(k) << 9);
        @(negedge clk_i);
        chk("source", k, positive_source_select_o[2*c+:2]);
        rd("control", ch_addr(c, acc_pkg::OFF_CTL0), 32'(k) << 9);
      end
    end
  endtask
  task t_irq;
    for (int c = 0; c < 3; c++) wr(ch_addr(c, acc_pkg::OFF_CTL0), 32'h8);
    wr(acc_pkg::OFF_MIS, 32'h7);
    rd("raw", acc_pkg::OFF_RIS, 32'h0);
    wr(acc_pkg::OFF_INTEN, 32'h7);
    @(negedge clk_i);
    chk("irq", 32'h0, irq_o);
    @(posedge clk_i);
    level <= 3'h7;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    chk("irq", 32'h1, irq_o);
    rd("raw", acc_pkg::OFF_RIS, 32'h7);
    rd("masked", acc_pkg::OFF_MIS, 32'h7);
    wr(acc_pkg::OFF_INTEN, 32'h2);
    rd("masked", acc_pkg::OFF_MIS, 32'h2);
    wr(acc_pkg::OFF_MIS, 32'h2);
    rd("raw", acc_pkg::OFF_RIS, 32'h5);
    rd("masked", acc_pkg::OFF_MIS, 32'h0);
    @(negedge clk_i);
    chk("irq", 32'h0, irq_o);
    wr(acc_pkg::OFF_INTEN, 32'h0);
  endtask
  task t_out;
    logic [31:0] d;
    for (int c = 0; c < 3; c++) begin
      // Shared pins take the reference as positive input while driving
      d = (c > 0) ? 32'h408 : 32'h008;
      wr(ch_addr(c, acc_pkg::OFF_CTL0), d | 32'h802);
      repeat (2) @(negedge clk_i);
      chk("out inv", 32'h0, comparison_out_o[c]);
      chk("out en", 32'h1, comparison_out_oe_o[c]);
      rd("status", ch_addr(c, acc_pkg::OFF_STAT0), 32'h0);
      wr(ch_addr(c, acc_pkg::OFF_CTL0), d);
      repeat (2) @(negedge clk_i);
      chk("out", 32'h1, comparison_out_o[c]);
      chk("out off", 32'h0, comparison_out_oe_o[c]);
      rd("status", ch_addr(c, acc_pkg::OFF_STAT0), 32'h2);
      @(posedge clk_i);
      level[c] <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk("out early", 32'h1, comparison_out_o[c]);
      repeat (8) @(negedge clk_i);
      chk("out late", 32'h0, comparison_out_o[c]);
      @(posedge clk_i);
    end
  endtask
  // Reset in mid-run must bring the ladder and its register back to zero
  task t_reset_mid;
    wr(acc_pkg::OFF_REFCTL, 32'h20F);
    repeat (2) @(negedge clk_i);
    chk("tap before reset", 32'h17, ref_tap_o);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk("tap after reset", 32'h0, ref_tap_o);
    chk("irq after reset", 32'h0, irq_o);
    rd("refctl", acc_pkg::OFF_REFCTL, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset_vals();
    t_ref();
    t_src();
    t_irq();
    t_out();
    t_reset_mid();
    final_report();
  end
endmodule  // tb
bind acc_top acc_asserts u_chk (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .comparison_result_i(comparison_result_i), .positive_source_select_o(positive_source_select_o),
  .comparison_out_o(comparison_out_o), .comparison_out_oe_o(comparison_out_oe_o), .ref_enable_o(ref_enable_o),
  .reference_range_select_o(reference_range_select_o), .ref_tap_o(ref_tap_o), .irq_o(irq_o));
`default_nettype wire
